/* logic/pdc_core.sv */
/*
 pre-driver control core: pin synchronisers, command decode, fault flag,
 per-leg dead-time and interlock, gate drive outputs.
 assumes analogue comparators present digital levels and that the serial
 clock is unrelated to the core clock.
*/
`timescale 1ns/1ps
module pdc_core (
    // clock and resets
    input wire logic clock,
    input wire logic rst_n,
    input wire logic supply_ok,
    // gate enables
    input wire logic gate_enable_first,
    input wire logic gate_enable_second,
    // phase commands
    input wire logic leg_a_upper_cmd_n,
    input wire logic leg_a_lower_cmd,
    input wire logic leg_b_upper_cmd_n,
    input wire logic leg_b_lower_cmd,
    input wire logic leg_c_upper_cmd_n,
    input wire logic leg_c_lower_cmd,
    // comparator levels
    input wire logic [pdc_pkg::LEGS-1:0] leg_mid_above_half,
    input wire logic overcurrent_detect,
    input wire logic [pdc_pkg::FAULTS-1:0] fault_source,
    // serial port
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdi,
    output logic sdo,
    output logic sdo_oe_n,
    // gate drives
    output logic [pdc_pkg::LEGS-1:0] upper_switch,
    output logic [pdc_pkg::LEGS-1:0] lower_switch,
    output logic gate_hiz,
    output logic gate_weak_pulldown,
    // flags
    output logic fault_flag,
    output logic leg_a_midpoint_flag,
    output logic leg_b_midpoint_flag,
    output logic leg_c_midpoint_flag,
    output logic overcurrent_flag
);
    import pdc_pkg::*;

    wire core_rst_n;
    wire gate_rst_n;
    wire [IN_W-1:0] raw_in;
    logic [IN_W-1:0] sync1_ff;
    logic [IN_W-1:0] sync2_ff;
    wire en_ok;
    wire [LEGS-1:0] upper_req;
    wire [LEGS-1:0] lower_req;
    wire [LEGS-1:0] mid_s;
    wire oc_s;
    wire [FAULTS-1:0] flt_s;

    pdc_frame_s rx_word;
    wire rx_tgl;
    logic tgl1_ff;
    logic tgl2_ff;
    logic tgl3_ff;
    wire frame_new;
    wire clr_pulse;
    wire [7:0] dt_clip;
    pdc_cfg_s cfg_ff;
    pdc_cfg_s nxt_cfg;
    wire [DT_CNT_W-1:0] dt_cycles;
    wire dt_skip;

    wire [FAULTS-1:0] filt_all;
    wire fault_hit;
    logic fault_flag_ff;
    logic [FAULTS-1:0] fault_lat_ff;
    pdc_status_s status_ff;
    pdc_status_s nxt_status;

    logic [LEGS-1:0] mid_ff;
    logic oc_ff;
    logic hiz_ff;
    logic weak_pd_ff;
    wire [LEGS-1:0] upper_sw_w;
    wire [LEGS-1:0] lower_sw_w;

    // supply monitor and reset pin both clear the logic at once
    assign core_rst_n = rst_n & supply_ok;
    // enables clear the drive flops without a clock
    assign gate_rst_n = core_rst_n & gate_enable_first
        & gate_enable_second;

    // pin synchronisers
    assign raw_in = {fault_source, overcurrent_detect, leg_mid_above_half,
        leg_c_lower_cmd, leg_b_lower_cmd, leg_a_lower_cmd,
        leg_c_upper_cmd_n, leg_b_upper_cmd_n, leg_a_upper_cmd_n,
        gate_enable_second, gate_enable_first};

    always_ff @(posedge clock or negedge core_rst_n)
    begin
        if (!core_rst_n)
        begin
            sync1_ff <= '0;
            sync2_ff <= '0;
        end
        else
        begin
            sync1_ff <= raw_in;
            sync2_ff <= sync1_ff;
        end
    end

    assign en_ok = &sync2_ff[IDX_EN +: 2];
    assign upper_req = ~sync2_ff[IDX_UP +: LEGS];
    assign lower_req = sync2_ff[IDX_LO +: LEGS];
    assign mid_s = sync2_ff[IDX_MID +: LEGS];
    assign oc_s = sync2_ff[IDX_OC];
    assign flt_s = sync2_ff[IDX_FLT +: FAULTS];

    // serial port, frames arrive by toggle
    pdc_serial_link u_link (
        .sclk(sclk),
        .cs_n(cs_n),
        .sdi(sdi),
        .sdo(sdo),
        .sdo_oe_n(sdo_oe_n),
        .rst_n(core_rst_n),
        .status(status_ff),
        .rx_word(rx_word),
        .rx_tgl(rx_tgl)
    );

    always_ff @(posedge clock or negedge core_rst_n)
    begin
        if (!core_rst_n)
        begin
            tgl1_ff <= 1'b0;
            tgl2_ff <= 1'b0;
            tgl3_ff <= 1'b0;
        end
        else
        begin
            tgl1_ff <= rx_tgl;
            tgl2_ff <= tgl1_ff;
            tgl3_ff <= tgl2_ff;
        end
    end

    assign frame_new = tgl2_ff ^ tgl3_ff;
    assign clr_pulse = frame_new && rx_word.op == OP_CLEAR;
    assign dt_clip = (rx_word.arg[7:0] > DT_CODE_MAX) ? DT_CODE_MAX
        : rx_word.arg[7:0];

    always_comb
    begin
        nxt_cfg = cfg_ff;
        if (frame_new)
        begin
            unique case (rx_word.op)
                OP_FILT_ZERO: nxt_cfg.filt_zero = rx_word.arg[3:0];
                OP_FILT_ONE: nxt_cfg.filt_one = rx_word.arg[3:0];
                OP_DEADTIME: nxt_cfg.dt_code = dt_clip;
                OP_MODE:
                begin
                    nxt_cfg.dt_off = rx_word.arg[MODE_DT_OFF];
                    nxt_cfg.ilk_off = rx_word.arg[MODE_ILK_OFF];
                end
                default: nxt_cfg = cfg_ff;
            endcase
        end
    end

    always_ff @(posedge clock or negedge core_rst_n)
    begin
        if (!core_rst_n)
            cfg_ff <= {FILT_RST, FILT_RST, DT_RST, 1'b0, 1'b0};
        else
            cfg_ff <= nxt_cfg;
    end

    assign dt_cycles = DT_CNT_W'(cfg_ff.dt_code * DT_STEP_CYC);
    assign dt_skip = cfg_ff.dt_off || dt_cycles == '0;

    // fault flag, set wins over clear
    assign filt_all = {cfg_ff.filt_one, cfg_ff.filt_zero};
    assign fault_hit = |(flt_s & ~filt_all);

    always_comb
    begin
        nxt_status.fault_flag = fault_flag_ff;
        nxt_status.ilk_off = cfg_ff.ilk_off;
        nxt_status.dt_off = cfg_ff.dt_off;
        nxt_status.en_ok = en_ok;
        nxt_status.zero = 4'h0;
        nxt_status.fault_lat = fault_lat_ff;
    end

    always_ff @(posedge clock or negedge core_rst_n)
    begin
        if (!core_rst_n)
        begin
            fault_flag_ff <= 1'b0;
            fault_lat_ff <= '0;
            status_ff <= STATUS_RST;
        end
        else
        begin
            fault_flag_ff <= fault_hit | (fault_flag_ff & ~clr_pulse);
            fault_lat_ff <= flt_s | (fault_lat_ff & {FAULTS{~clr_pulse}});
            if (frame_new)
                status_ff <= nxt_status;
        end
    end

    // comparator flags
    always_ff @(posedge clock or negedge core_rst_n)
    begin
        if (!core_rst_n)
        begin
            mid_ff <= '0;
            oc_ff <= 1'b0;
        end
        else
        begin
            mid_ff <= mid_s;
            oc_ff <= oc_s;
        end
    end

    // drive state during reset and supply ramp
    always_ff @(posedge clock or negedge supply_ok)
    begin
        if (!supply_ok)
            hiz_ff <= 1'b1;
        else
            hiz_ff <= 1'b0;
    end

    always_ff @(posedge clock or negedge core_rst_n)
    begin
        if (!core_rst_n)
            weak_pd_ff <= 1'b1;
        else
            weak_pd_ff <= 1'b0;
    end

    // per-leg dead-time, interlock and precharge
    for (genvar g = 0; g < LEGS; g++)
    begin : leg
        pdc_leg_e st_ff;
        pdc_leg_e nxt_st;
        logic [1:0] last_ff;
        logic [1:0] nxt_last;
        logic [DT_CNT_W-1:0] cnt_ff;
        logic [DT_CNT_W-1:0] nxt_cnt;
        logic up_ff;
        logic lo_ff;
        logic armed_ff;
        wire [1:0] raw_want;
        wire [1:0] want;
        wire changed;
        wire [1:0] drive;

        assign raw_want = {upper_req[g] & armed_ff, lower_req[g]};
        assign want = (&raw_want && !cfg_ff.ilk_off) ? 2'b00
            : raw_want;
        assign changed = want != last_ff;

        always_comb
        begin
            nxt_st = st_ff;
            nxt_last = last_ff;
            nxt_cnt = cnt_ff;
            if (changed)
            begin
                nxt_last = want;
                nxt_cnt = dt_cycles;
                nxt_st = dt_skip ? LEG_DRIVE : LEG_DEAD;
            end
            else
            begin
                unique case (st_ff)
                    LEG_OPEN: nxt_st = LEG_OPEN;
                    LEG_DRIVE: nxt_st = LEG_DRIVE;
                    LEG_DEAD:
                    begin
                        if (cnt_ff <= DT_CNT_W'(1))
                            nxt_st = LEG_DRIVE;
                        else
                            nxt_cnt = cnt_ff - DT_CNT_W'(1);
                    end
                    default: nxt_st = LEG_OPEN;
                endcase
            end
        end

        assign drive = (nxt_st == LEG_DRIVE) ? nxt_last : 2'b00;

        always_ff @(posedge clock or negedge core_rst_n)
        begin
            if (!core_rst_n)
            begin
                st_ff <= LEG_OPEN;
                last_ff <= 2'b00;
                cnt_ff <= '0;
            end
            else
            begin
                st_ff <= nxt_st;
                last_ff <= nxt_last;
                cnt_ff <= nxt_cnt;
            end
        end

        always_ff @(posedge clock or negedge gate_rst_n)
        begin
            if (!gate_rst_n)
            begin
                up_ff <= 1'b0;
                lo_ff <= 1'b0;
                armed_ff <= 1'b0;
            end
            else
            begin
                up_ff <= drive[1] & en_ok;
                lo_ff <= drive[0] & en_ok;
                armed_ff <= armed_ff | lo_ff;
            end
        end

        assign upper_sw_w[g] = up_ff;
        assign lower_sw_w[g] = lo_ff;

        precharge_order_a: assert property (@(posedge clock)
            disable iff (!core_rst_n) $rose(up_ff) |-> armed_ff)
            else $error("upper leg on before lower leg pulse");

        leg_interlock_a: assert property (@(posedge clock)
            disable iff (!core_rst_n)
            (!cfg_ff.ilk_off && !$past(cfg_ff.ilk_off)) |-> !(up_ff && lo_ff))
            else $error("both drives of one leg on");

        dead_gap_a: assert property (@(posedge clock)
            disable iff (!core_rst_n)
            (changed && !dt_skip) |=> (!up_ff && !lo_ff) [*2])
            else $error("drive on inside dead time");
    end

    assign upper_switch = upper_sw_w;
    assign lower_switch = lower_sw_w;
    assign gate_hiz = hiz_ff;
    assign gate_weak_pulldown = weak_pd_ff;
    assign fault_flag = fault_flag_ff;
    assign leg_a_midpoint_flag = mid_ff[0];
    assign leg_b_midpoint_flag = mid_ff[1];
    assign leg_c_midpoint_flag = mid_ff[2];
    assign overcurrent_flag = oc_ff;

    enable_gate_a: assert property (@(posedge clock)
        disable iff (!core_rst_n)
        (|upper_sw_w || |lower_sw_w) |-> (gate_enable_first
            && gate_enable_second && $past(en_ok)))
        else $error("drive on without both enables");

    enable_off_a: assert property (@(posedge clock)
        disable iff (!core_rst_n)
        (!gate_enable_first || !gate_enable_second)
            |-> (upper_sw_w == '0 && lower_sw_w == '0))
        else $error("drive on while an enable is low");

    fault_set_a: assert property (@(posedge clock)
        disable iff (!core_rst_n) fault_hit |=> fault_flag_ff)
        else $error("unmasked fault did not raise flag");

    fault_hold_a: assert property (@(posedge clock)
        disable iff (!core_rst_n)
        (fault_flag_ff && !clr_pulse) |=> fault_flag_ff)
        else $error("fault flag dropped without clear");

    fault_mask_a: assert property (@(posedge clock)
        disable iff (!core_rst_n)
        (!fault_flag_ff && (flt_s & ~filt_all) == '0) |=> !fault_flag_ff)
        else $error("masked fault raised flag");

    mid_flag_a: assert property (@(posedge clock)
        disable iff (!core_rst_n)
        $past(sync1_ff[IDX_MID +: LEGS], 2) == mid_ff)
        else $error("midpoint flag does not follow comparator");

    oc_flag_a: assert property (@(posedge clock)
        disable iff (!core_rst_n) $past(sync1_ff[IDX_OC], 2) == oc_ff)
        else $error("overcurrent flag does not follow comparator");

    dt_range_a: assert property (@(posedge clock)
        disable iff (!core_rst_n) cfg_ff.dt_code <= DT_CODE_MAX)
        else $error("dead-time code above range");
endmodule

/* logic/pdc_pkg.sv */
/*
 constants, field layouts and carrier types of the pre-driver control block.
 assumes a 100 MHz core clock and a 16-bit serial frame, most significant
 bit first.
*/
// Functional notes
// - gate drives may turn on only while both enables are high
// - either enable low forces all drives off; serial and logic keep running
// - enable gating acts at once, without waiting for a clock edge
// - upper leg may turn on only after its lower leg pulsed since enable
// - reset low: outputs disabled, weak pull-down on gate drives
// - internal logic cleared within 77 ns of reset going low
// - below supply threshold: logic reset, drives hi-z, serial ignored
// - midpoint flag low while leg midpoint below half supply, else high
// - upper commands active low, undriven reads inactive
// - lower commands active high, undriven reads inactive
// - unmasked fault raises fault flag until the clear command
// - two filter registers suppress individual fault sources
// - chip select low frames a command; port active only while low
// - serial input sampled on falling clock edges, msb first
// - serial output hi-z when deselected, new bit on rising edges
// - overcurrent flag high while overcurrent present, else low
// - dead-time and interlock keep one leg's drives apart, both defeatable
// - dead-time set over serial, 50 ns steps from 0 to 12 us
package pdc_pkg;
    localparam int CLK_MHZ = 100;
    localparam int RST_CLEAR_NS = 77;
    localparam int RST_CLEAR_CYC = (RST_CLEAR_NS * CLK_MHZ) / 1000;
    localparam int DT_STEP_NS = 50;
    localparam int DT_MAX_NS = 12000;
    localparam int DT_STEP_CYC = (DT_STEP_NS * CLK_MHZ + 999) / 1000;
    localparam logic [7:0] DT_CODE_MAX = 8'(DT_MAX_NS / DT_STEP_NS);
    localparam int DT_CNT_W = 11;

    localparam int LEGS = 3;
    localparam int FAULTS = 8;
    localparam int FRAME_BITS = 16;
    localparam int BIT_CNT_W = 4;

    // synchroniser vector layout
    localparam int IDX_EN = 0;
    localparam int IDX_UP = 2;
    localparam int IDX_LO = 5;
    localparam int IDX_MID = 8;
    localparam int IDX_OC = 11;
    localparam int IDX_FLT = 12;
    localparam int IN_W = 20;

    // command codes in frame bits 15:12
    localparam logic [3:0] OP_NULL = 4'h0;
    localparam logic [3:0] OP_FILT_ZERO = 4'h1;
    localparam logic [3:0] OP_FILT_ONE = 4'h2;
    localparam logic [3:0] OP_DEADTIME = 4'h3;
    localparam logic [3:0] OP_MODE = 4'h4;
    localparam logic [3:0] OP_CLEAR = 4'h5;

    // mode argument bits
    localparam int MODE_DT_OFF = 0;
    localparam int MODE_ILK_OFF = 1;

    // reset values
    localparam logic [3:0] FILT_RST = 4'h0;
    localparam logic [7:0] DT_RST = 8'h00;
    localparam logic [15:0] STATUS_RST = 16'h0000;

    typedef struct packed {
        logic [3:0] op;
        logic [11:0] arg;
    } pdc_frame_s;

    typedef struct packed {
        logic [3:0] filt_one;
        logic [3:0] filt_zero;
        logic [7:0] dt_code;
        logic dt_off;
        logic ilk_off;
    } pdc_cfg_s;

    typedef struct packed {
        logic fault_flag;
        logic ilk_off;
        logic dt_off;
        logic en_ok;
        logic [3:0] zero;
        logic [7:0] fault_lat;
    } pdc_status_s;

    typedef enum logic [2:0] {
        LEG_OPEN = 3'b001,
        LEG_DEAD = 3'b010,
        LEG_DRIVE = 3'b100
    } pdc_leg_e;
endpackage

/* logic/pdc_serial_link.sv */
/*
 serial port end of the pre-driver control: shifts frames in and status out
 on the serial clock. assumes the serial clock runs only inside frames and
 that the core picks up each frame by synchronising the done toggle.
*/
`timescale 1ns/1ps
module pdc_serial_link (
    // serial pins
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdi,
    output logic sdo,
    output logic sdo_oe_n,
    // core side
    input wire logic rst_n,
    input wire logic [15:0] status,
    output pdc_pkg::pdc_frame_s rx_word,
    output logic rx_tgl
);
    import pdc_pkg::*;

    logic [BIT_CNT_W-1:0] rx_cnt_ff;
    logic [BIT_CNT_W-1:0] tx_cnt_ff;
    logic [FRAME_BITS-1:0] shift_ff;
    pdc_frame_s word_ff;
    logic tgl_ff;
    logic sdo_ff;
    logic oe_n_ff;
    wire link_rst_n;

    // deselect or core reset clears the frame position
    assign link_rst_n = rst_n & ~cs_n;

    always_ff @(negedge sclk or negedge link_rst_n)
    begin
        if (!link_rst_n)
        begin
            rx_cnt_ff <= '0;
            shift_ff <= '0;
        end
        else
        begin
            rx_cnt_ff <= rx_cnt_ff + 4'h1;
            shift_ff <= {shift_ff[FRAME_BITS-2:0], sdi};
        end
    end

    // whole frame handed over with a toggle
    always_ff @(negedge sclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            word_ff <= '0;
            tgl_ff <= 1'b0;
        end
        else if (link_rst_n && rx_cnt_ff == 4'hf)
        begin
            word_ff <= {shift_ff[FRAME_BITS-2:0], sdi};
            tgl_ff <= ~tgl_ff;
        end
    end

    always_ff @(posedge sclk or negedge link_rst_n)
    begin
        if (!link_rst_n)
        begin
            tx_cnt_ff <= '0;
            sdo_ff <= 1'b0;
            oe_n_ff <= 1'b1;
        end
        else
        begin
            tx_cnt_ff <= tx_cnt_ff + 4'h1;
            sdo_ff <= status[~tx_cnt_ff];
            oe_n_ff <= 1'b0;
        end
    end

    assign sdo = sdo_ff;
    assign sdo_oe_n = oe_n_ff;
    assign rx_word = word_ff;
    assign rx_tgl = tgl_ff;

    msb_first_a: assert property (@(negedge sclk) disable iff (!rst_n)
        (rx_cnt_ff == 4'hf) |=> (word_ff[0] == $past(sdi)
            && word_ff[15:1] == $past(shift_ff[14:0])))
        else $error("frame not assembled msb first");

    sdo_drive_a: assert property (@(negedge sclk) disable iff (cs_n)
        !oe_n_ff && sdo_ff == status[~(tx_cnt_ff - 4'h1)])
        else $error("serial output not driven with status bit");
endmodule

/* tb/pdc_mcu_model.sv */
/*
 controller model on the serial port: frames commands and reads status.
 assumes the device samples on falling and drives sdo on rising sclk.
*/
`timescale 1ns/1ps
module pdc_mcu_model (
    // serial pins
    output logic sclk,
    output logic cs_n,
    output logic sdi,
    input wire logic sdo,
    input wire logic sdo_oe_n
);
    import pdc_pkg::*;
    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b0;
        sdi = 1'b0;
        // deselect after the power-up reset edge clears the link
        #2 cs_n = 1'b1;
    end
    // one whole frame; sclk idles low, sdi falls to its pull-down
    task automatic xfer(input pdc_frame_s tx, output logic [15:0] rx);
        cs_n = 1'b0;
        #20;
        for (int i = 15; i >= 0; i--)
        begin
            sdi = tx[i];
            #3 sclk = 1'b1;
            #6 sclk = 1'b0;
            rx[i] = sdo;
            #3;
        end
        #20 cs_n = 1'b1;
        sdi = 1'b0;
        #200;
    endtask
endmodule

/* tb/tb_top.sv */
/*
 testbench of the pre-driver control core: pin stimulus and serial frames.
 assumes the serial model above and the core latencies of the hand-over.
*/
`timescale 1ns/1ps
module tb_top;
    import pdc_pkg::*;
    logic clock = 1'b0;
    logic rst_n = 1'b1;
    logic supply_ok = 1'b1;
    logic en1 = 1'b0;
    logic en2 = 1'b0;
    logic [2:0] up_n = 3'h7;
    logic [2:0] lo = 3'h0;
    logic [2:0] mid = 3'h0;
    logic oc = 1'b0;
    logic [7:0] flt = 8'h00;
    logic sclk, cs_n, sdi, sdo, sdo_oe_n;
    logic [2:0] up_sw, lo_sw;
    logic hiz, wpd, fault, fa, fb, fc, ocf;
    logic [15:0] rx;
    int n_mismatch = 0;
    int n_tests = 0;
    int cyc = 0;

    always #5 clock = ~clock;

    pdc_mcu_model mcu (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo),
        .sdo_oe_n(sdo_oe_n));

    pdc_core dut (.clock(clock), .rst_n(rst_n), .supply_ok(supply_ok),
        .gate_enable_first(en1), .gate_enable_second(en2),
        .leg_a_upper_cmd_n(up_n[0]), .leg_a_lower_cmd(lo[0]),
        .leg_b_upper_cmd_n(up_n[1]), .leg_b_lower_cmd(lo[1]),
        .leg_c_upper_cmd_n(up_n[2]), .leg_c_lower_cmd(lo[2]),
        .leg_mid_above_half(mid), .overcurrent_detect(oc),
        .fault_source(flt), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
        .sdo(sdo), .sdo_oe_n(sdo_oe_n), .upper_switch(up_sw),
        .lower_switch(lo_sw), .gate_hiz(hiz), .gate_weak_pulldown(wpd),
        .fault_flag(fault), .leg_a_midpoint_flag(fa),
        .leg_b_midpoint_flag(fb), .leg_c_midpoint_flag(fc),
        .overcurrent_flag(ocf));

    task automatic chk(input string nm, input logic [15:0] e,
        input logic [15:0] g);
        n_tests++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge clock);
    endtask

    task automatic cmd(input logic [3:0] op, input logic [11:0] arg);
        mcu.xfer(pdc_frame_s'{op: op, arg: arg}, rx);
        wt(6);
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    always @(posedge clock)
    begin
        cyc++;
        if (cyc > 20000)
        begin
            n_mismatch++;
            complete_run();
        end
    end

    initial
    begin
        #1 rst_n <= 1'b0;
        supply_ok <= 1'b0;
        #1 chk("gate_hiz", 16'h1, hiz);
        chk("pulldown", 16'h1, wpd);
        wt(3);
        supply_ok <= 1'b1;
        wt(2);
        rst_n <= 1'b1;
        wt(3);
        chk("released", 16'h0, {hiz, wpd, fault, up_sw, lo_sw});
        chk("sdo_oe_n idle", 16'h1, sdo_oe_n);
        en1 <= 1'b1;
        en2 <= 1'b1;
        up_n[1] <= 1'b0;
        wt(8);
        chk("upper b", 16'h0, up_sw);
        up_n[1] <= 1'b1;
        lo[0] <= 1'b1;
        wt(6);
        chk("lower a on", 16'h1, lo_sw);
        lo[0] <= 1'b0;
        wt(6);
        chk("lower a off", 16'h0, lo_sw);
        up_n[0] <= 1'b0;
        wt(6);
        chk("upper a on", 16'h1, up_sw);
        lo[0] <= 1'b1;
        wt(8);
        chk("interlock", 16'h0, {up_sw[0], lo_sw[0]});
        cmd(OP_MODE, 12'h002);
        chk("ilk off", 16'h3, {up_sw[0], lo_sw[0]});
        cmd(OP_MODE, 12'h000);
        lo[0] <= 1'b0;
        wt(6);
        en2 <= 1'b0;
        #2 chk("async gate", 16'h0, up_sw);
        wt(3);
        en2 <= 1'b1;
        wt(8);
        chk("precharge", 16'h0, up_sw);
        cmd(OP_DEADTIME, 12'h002);
        lo[2] <= 1'b1;
        wt(10);
        chk("dead hold", 16'h0, lo_sw);
        wt(6);
        chk("dead done", 16'h4, lo_sw);
        lo[2] <= 1'b0;
        cmd(OP_MODE, 12'h001);
        lo[2] <= 1'b1;
        wt(5);
        chk("dead off", 16'h4, lo_sw);
        flt[0] <= 1'b1;
        wt(5);
        chk("fault set", 16'h1, fault);
        flt[0] <= 1'b0;
        cmd(OP_NULL, 12'h000);
        chk("fault held", 16'h1, fault);
        cmd(OP_NULL, 12'h000);
        chk("status", 16'hb001, rx);
        cmd(OP_CLEAR, 12'h000);
        chk("fault clear", 16'h0, fault);
        cmd(OP_FILT_ZERO, 12'h001);
        flt[0] <= 1'b1;
        wt(6);
        chk("masked", 16'h0, fault);
        flt[4] <= 1'b1;
        wt(6);
        chk("unmasked", 16'h1, fault);
        mid <= 3'b101;
        oc <= 1'b1;
        wt(5);
        chk("midpoint", 16'h5, {fc, fb, fa});
        chk("overcurrent", 16'h1, ocf);
        oc <= 1'b0;
        wt(5);
        chk("oc low", 16'h0, ocf);
        cmd(OP_MODE, 12'h000);
        cmd(OP_DEADTIME, 12'h0ff);
        lo[1] <= 1'b1;
        wt(1200);
        chk("dead sat hold", 16'h4, lo_sw);
        wt(5);
        chk("dead sat done", 16'h6, lo_sw);
        rst_n <= 1'b0;
        #7 chk("reset", 16'h1, {fault, lo_sw, wpd});
        wt(2);
        rst_n <= 1'b1;
        wt(3);
        complete_run();
    end
endmodule
